// ---- rtl/pondt_pkg.sv ----
// constants for the pattern output next-data trigger block
package pondt_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_NEXT_UPPER_A = 32'h005ffff4;
  localparam logic [31:0] IDX_NEXT_UPPER_B = 32'h005ffff6;
  localparam logic [31:0] IDX_ENABLE_HIGH = 32'h005ffff0;
  localparam logic [31:0] IDX_ENABLE_LOW = 32'h005ffff1;
  localparam logic [31:0] IDX_PORT_DATA = 32'h005ffff2;
  localparam logic [31:0] IDX_TRIG_SEL = 32'h005ffff3;
  localparam logic [31:0] IDX_NEXT_LOWER = 32'h005ffff5;
  localparam logic [31:0] BYTES_PER_REG = 32'h00000004;

  localparam logic [31:0] ADDR_NEXT_UPPER_A = IDX_NEXT_UPPER_A * BYTES_PER_REG;
  localparam logic [31:0] ADDR_NEXT_UPPER_B = IDX_NEXT_UPPER_B * BYTES_PER_REG;
  localparam logic [31:0] ADDR_ENABLE_HIGH = IDX_ENABLE_HIGH * BYTES_PER_REG;
  localparam logic [31:0] ADDR_ENABLE_LOW = IDX_ENABLE_LOW * BYTES_PER_REG;
  localparam logic [31:0] ADDR_PORT_DATA = IDX_PORT_DATA * BYTES_PER_REG;
  localparam logic [31:0] ADDR_TRIG_SEL = IDX_TRIG_SEL * BYTES_PER_REG;
  localparam logic [31:0] ADDR_NEXT_LOWER = IDX_NEXT_LOWER * BYTES_PER_REG;

  // values after reset
  localparam logic [7:0] RST_NEXT = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_TRIG_SEL = 8'hff;
  localparam logic [15:0] RST_PORT_DATA = 16'h0000;

  // reserved bits read back as ones
  localparam logic [7:0] RSVD_BYTE = 8'hff;
  localparam logic [3:0] RSVD_NIBBLE = 4'hf;

  // trigger select field positions (low bit of each two-bit field)
  localparam int GRP3_SEL_LSB = 6;
  localparam int GRP2_SEL_LSB = 4;

  // group geometry
  localparam int GROUP_COUNT = 4;
  localparam int GROUP_WIDTH = 4;
  localparam int CHANNEL_COUNT = 4;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/pondt_reg_if.sv ----
// register access carrier between bus slave and register file
`timescale 1ns/1ns
`default_nettype none
interface pondt_reg_if #(
  parameter int ADDR_W = 32
);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok
  );
  modport regs (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok
  );
endinterface
`default_nettype wire

// ---- rtl/pondt_axil.sv ----
// axi4-lite slave front end for the pattern output registers
`timescale 1ns/1ns
`default_nettype none
module pondt_axil #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write address and data
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // write response
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // read address and data
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // register side
  pondt_reg_if.bus reg_if
);
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_take;
  logic w_take;

  // one write and one read in flight
  assign awready_o = !aw_full && !bvalid_o;
  assign wready_o = !w_full && !bvalid_o;
  assign aw_take = awvalid_i && awready_o;
  assign w_take = wvalid_i && wready_o;
  assign arready_o = !rvalid_o;

  assign reg_if.wr_en = aw_full && w_full && !bvalid_o;
  assign reg_if.wr_addr = aw_addr;
  assign reg_if.wr_data = w_data;
  assign reg_if.wr_strb = w_strb;
  assign reg_if.rd_en = arvalid_i && arready_o;
  assign reg_if.rd_addr = araddr_i;

  // write side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= pondt_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr_i;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (reg_if.wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= reg_if.wr_ok ? pondt_pkg::RESP_OKAY : pondt_pkg::RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // read side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= pondt_pkg::RESP_OKAY;
    end else if (reg_if.rd_en) begin
      rvalid_o <= 1'b1;
      rdata_o <= reg_if.rd_data;
      rresp_o <= reg_if.rd_ok ? pondt_pkg::RESP_OKAY : pondt_pkg::RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end
  end
endmodule // pondt_axil
`default_nettype wire

// ---- rtl/pondt_top.sv ----
// pattern output staging, enables, trigger select and port data register
// Function
// - upper next-data register is 8 bits, reset to zero, kept in standby.
// - selected compare-match copies staged group bits into port output data.
// - shared group 3/2 trigger: whole byte at first address, 3 high, 2 low.
// - shared trigger: second address is reserved, reads ones, writes ignored.
// - split trigger: group 3 high nibble first address, group 2 low nibble second.
// - split trigger: the unused nibbles at both addresses read ones, writes ignored.
// - low enable register gates pins 7..0 per bit; zero keeps the output.
// - high enable register gates pins 15..8 per bit; zero keeps the output.
// - both enable registers reset to zero and keep contents in standby.
// - trigger select resets to all ones, channel 3 for every group.
// - trigger select bits 7:6 pick the channel for group 3.
// - trigger select bits 5:4 pick the channel for group 2.
// - trigger select bits 3:2 pick the channel for group 1.
// - trigger select bits 1:0 pick the channel for group 0.
// - port data bits with enable set ignore software writes.
`timescale 1ns/1ns
`default_nettype none
module pondt_top #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // timer compare-match pulses, one per channel
  input wire logic [3:0] CMP_MATCH_I,
  // pattern pins and their enables
  output logic [15:0] PATTERN_PINS_O,
  output logic [15:0] PATTERN_ENABLE_O
);
  localparam int GW = pondt_pkg::GROUP_WIDTH;

  if (ADDR_W < 26 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 26 and 32");
  end

  // register file state
  logic [7:0] next_pattern_upper;
  logic [7:0] next_pattern_lower;
  logic [7:0] pattern_enable_low;
  logic [7:0] pattern_enable_high;
  logic [7:0] pattern_trigger_select;
  logic [15:0] port_output_data;
  logic [15:0] next_port_output_data;

  pondt_reg_if #(.ADDR_W(ADDR_W)) reg_if ();

  pondt_axil #(.ADDR_W(ADDR_W)) u_axil (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .awaddr_i(S_AXI_AWADDR_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .bresp_o(S_AXI_BRESP_O),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .araddr_i(S_AXI_ARADDR_I),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .reg_if(reg_if)
  );

  // layout choice for the upper staging register
  wire logic shared_trig;
  assign shared_trig = pattern_trigger_select[pondt_pkg::GRP3_SEL_LSB +: 2] ==
                       pattern_trigger_select[pondt_pkg::GRP2_SEL_LSB +: 2];

  // write decode
  wire logic [ADDR_W-1:0] wa;
  wire logic lane0;
  wire logic lane1;
  wire logic wr_up_a;
  wire logic wr_up_b;
  wire logic wr_low;
  wire logic wr_en_lo;
  wire logic wr_en_hi;
  wire logic wr_sel;
  wire logic wr_port;
  assign wa = reg_if.wr_addr;
  assign lane0 = reg_if.wr_en && reg_if.wr_strb[0];
  assign lane1 = reg_if.wr_en && reg_if.wr_strb[1];
  assign wr_up_a = lane0 && (wa == ADDR_W'(pondt_pkg::ADDR_NEXT_UPPER_A));
  assign wr_up_b = lane0 && (wa == ADDR_W'(pondt_pkg::ADDR_NEXT_UPPER_B));
  assign wr_low = lane0 && (wa == ADDR_W'(pondt_pkg::ADDR_NEXT_LOWER));
  assign wr_en_lo = lane0 && (wa == ADDR_W'(pondt_pkg::ADDR_ENABLE_LOW));
  assign wr_en_hi = lane0 && (wa == ADDR_W'(pondt_pkg::ADDR_ENABLE_HIGH));
  assign wr_sel = lane0 && (wa == ADDR_W'(pondt_pkg::ADDR_TRIG_SEL));
  assign wr_port = (wa == ADDR_W'(pondt_pkg::ADDR_PORT_DATA));

  wire logic wr_hit;
  assign wr_hit = (wa == ADDR_W'(pondt_pkg::ADDR_NEXT_UPPER_A)) ||
                  (wa == ADDR_W'(pondt_pkg::ADDR_NEXT_UPPER_B)) ||
                  (wa == ADDR_W'(pondt_pkg::ADDR_NEXT_LOWER)) ||
                  (wa == ADDR_W'(pondt_pkg::ADDR_ENABLE_LOW)) ||
                  (wa == ADDR_W'(pondt_pkg::ADDR_ENABLE_HIGH)) ||
                  (wa == ADDR_W'(pondt_pkg::ADDR_TRIG_SEL)) || wr_port;
  assign reg_if.wr_ok = wr_hit;

  // next value of the upper staging byte per layout
  wire logic [7:0] wd;
  wire logic [7:0] next_upper_a;
  wire logic [7:0] next_upper_b;
  assign wd = reg_if.wr_data[7:0];
  assign next_upper_a = shared_trig ? wd :
                        {wd[7:4], next_pattern_upper[3:0]};
  assign next_upper_b = shared_trig ? next_pattern_upper :
                        {next_pattern_upper[7:4], wd[3:0]};

  // staging and control registers
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      next_pattern_upper <= pondt_pkg::RST_NEXT;
      next_pattern_lower <= pondt_pkg::RST_NEXT;
      pattern_enable_low <= pondt_pkg::RST_ENABLE;
      pattern_enable_high <= pondt_pkg::RST_ENABLE;
      pattern_trigger_select <= pondt_pkg::RST_TRIG_SEL;
    end else begin
      if (wr_up_a) begin
        next_pattern_upper <= next_upper_a;
      end else if (wr_up_b) begin
        next_pattern_upper <= next_upper_b;
      end
      if (wr_low) begin
        next_pattern_lower <= wd;
      end
      if (wr_en_lo) begin
        pattern_enable_low <= wd;
      end
      if (wr_en_hi) begin
        pattern_enable_high <= wd;
      end
      if (wr_sel) begin
        pattern_trigger_select <= wd;
      end
    end
  end

  // per-group trigger pick and transfer
  wire logic [15:0] staged;
  wire logic [15:0] enables;
  wire logic [15:0] sw_lane;
  assign staged = {next_pattern_upper, next_pattern_lower};
  assign enables = {pattern_enable_high, pattern_enable_low};
  assign sw_lane = {{8{lane1 && wr_port}}, {8{lane0 && wr_port}}};

  for (genvar g = 0; g < pondt_pkg::GROUP_COUNT; g++) begin : g_grp
    wire logic [1:0] sel;
    wire logic fire;
    wire logic [GW-1:0] en;
    wire logic [GW-1:0] sw;
    assign sel = pattern_trigger_select[2*g +: 2];
    assign fire = CMP_MATCH_I[sel];
    assign en = enables[GW*g +: GW];
    assign sw = sw_lane[GW*g +: GW] & ~en;
    assign next_port_output_data[GW*g +: GW] =
      (fire ? (en & staged[GW*g +: GW]) | (~en & port_output_data[GW*g +: GW])
            : port_output_data[GW*g +: GW]) & ~sw |
      (reg_if.wr_data[GW*g +: GW] & sw);
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      port_output_data <= pondt_pkg::RST_PORT_DATA;
    end else begin
      port_output_data <= next_port_output_data;
    end
  end

  assign PATTERN_PINS_O = port_output_data;
  assign PATTERN_ENABLE_O = enables;

  // read decode
  wire logic [ADDR_W-1:0] ra;
  wire logic [7:0] rd_upper_a;
  wire logic [7:0] rd_upper_b;
  assign ra = reg_if.rd_addr;
  assign rd_upper_a = shared_trig ? next_pattern_upper :
                      {next_pattern_upper[7:4], pondt_pkg::RSVD_NIBBLE};
  assign rd_upper_b = shared_trig ? pondt_pkg::RSVD_BYTE :
                      {pondt_pkg::RSVD_NIBBLE, next_pattern_upper[3:0]};

  wire logic r_up_a;
  wire logic r_up_b;
  wire logic r_low;
  wire logic r_en_lo;
  wire logic r_en_hi;
  wire logic r_sel;
  wire logic r_port;
  assign r_up_a = ra == ADDR_W'(pondt_pkg::ADDR_NEXT_UPPER_A);
  assign r_up_b = ra == ADDR_W'(pondt_pkg::ADDR_NEXT_UPPER_B);
  assign r_low = ra == ADDR_W'(pondt_pkg::ADDR_NEXT_LOWER);
  assign r_en_lo = ra == ADDR_W'(pondt_pkg::ADDR_ENABLE_LOW);
  assign r_en_hi = ra == ADDR_W'(pondt_pkg::ADDR_ENABLE_HIGH);
  assign r_sel = ra == ADDR_W'(pondt_pkg::ADDR_TRIG_SEL);
  assign r_port = ra == ADDR_W'(pondt_pkg::ADDR_PORT_DATA);

  assign reg_if.rd_ok = r_up_a | r_up_b | r_low | r_en_lo | r_en_hi | r_sel | r_port;
  assign reg_if.rd_data =
    ({32{r_up_a}} & {24'h0, rd_upper_a}) |
    ({32{r_up_b}} & {24'h0, rd_upper_b}) |
    ({32{r_low}} & {24'h0, next_pattern_lower}) |
    ({32{r_en_lo}} & {24'h0, pattern_enable_low}) |
    ({32{r_en_hi}} & {24'h0, pattern_enable_high}) |
    ({32{r_sel}} & {24'h0, pattern_trigger_select}) |
    ({32{r_port}} & {16'h0, port_output_data});
endmodule // pondt_top
`default_nettype wire

// ---- verification/pondt_props.sv ----
// port-level checks for the pattern output block
`timescale 1ns/1ns
`default_nettype none
module pondt_props (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // bus handshakes
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // triggers and pins
  input wire logic [3:0] CMP_MATCH_I,
  input wire logic [15:0] PATTERN_PINS_O,
  input wire logic [15:0] PATTERN_ENABLE_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);
  chk_pins_quiet: assert property ($past(CMP_MATCH_I) == 4'h0 && !$rose(S_AXI_BVALID_O)
    |-> $stable(PATTERN_PINS_O)) else $error("pins moved without trigger or write");
  chk_off_bits_keep: assert property (!$rose(S_AXI_BVALID_O)
    |-> ((PATTERN_PINS_O ^ $past(PATTERN_PINS_O)) & ~$past(PATTERN_ENABLE_O)) == 16'h0)
    else $error("disabled pin changed on trigger");
  chk_on_bits_locked: assert property ($past(CMP_MATCH_I) == 4'h0
    |-> ((PATTERN_PINS_O ^ $past(PATTERN_PINS_O)) & $past(PATTERN_ENABLE_O)) == 16'h0)
    else $error("enabled pin changed without trigger");
  chk_en_quiet: assert property (!$rose(S_AXI_BVALID_O) |-> $stable(PATTERN_ENABLE_O))
    else $error("enables changed without write");
  chk_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O) else $error("write answer late");
  chk_b_release: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
    else $error("write answer not released");
  chk_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read answer late");
  chk_ar_blocked: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read taken while answer pending");
  cover property ($past(CMP_MATCH_I) != 4'h0 && $changed(PATTERN_PINS_O));
  cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'h2);
  cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule // pondt_props
bind pondt_top pondt_props u_props (.CLOCK_I, .SYS_RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .CMP_MATCH_I,
  .PATTERN_PINS_O, .PATTERN_ENABLE_O);
`default_nettype wire

// ---- verification/pondt_timer_model.sv ----
// timer channel model issuing compare-match pulses
`timescale 1ns/1ns
`default_nettype none
module pondt_timer_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request
  input wire logic start_i,
  input wire logic [1:0] chan_i,
  input wire logic [3:0] wait_i,
  // compare-match pulses
  output logic [3:0] cmp_o
);
  logic [3:0] cnt;
  logic [1:0] chan;
  logic run;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      chan <= 2'h0;
      run <= 1'b0;
      cmp_o <= 4'h0;
    end else begin
      cmp_o <= 4'h0;
      if (start_i && !run) begin
        run <= 1'b1;
        cnt <= wait_i;
        chan <= chan_i;
      end else if (run && cnt == 4'h0) begin
        run <= 1'b0;
        cmp_o <= 4'h1 << chan;
      end else if (run) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // pondt_timer_model
`default_nettype wire

// ---- verification/test_pattern_output_next_data_trigger.sv ----
// self-checking bench for the pattern output block
`timescale 1ns/1ns
`default_nettype none
module test_pattern_output_next_data_trigger;
  logic clk, rst, awv, wv, bre, arv, rre, go, awr, wrdy, bv, arr, rv;
  logic [31:0] awa, wd, ara, rd;
  logic [1:0] br, rr, ch;
  logic [3:0] dly, cmp;
  logic [15:0] pins, pen;
  logic [31:0] idx [7];
  int errors, check_count, m_hi, m_lo, m_en, m_sel, m_pins;
  pondt_top dut_u (.CLOCK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .CMP_MATCH_I(cmp),
    .PATTERN_PINS_O(pins), .PATTERN_ENABLE_O(pen));
  pondt_timer_model tmr_u (.clk_i(clk), .rst_i(rst), .start_i(go), .chan_i(ch), .wait_i(dly),
    .cmp_o(cmp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] rdv(input logic [31:0] i);
    logic sh;
    sh = m_sel[7:6] == m_sel[5:4];
    case (i)
      pondt_pkg::IDX_NEXT_UPPER_A: rdv = sh ? m_hi : {m_hi[7:4], 4'hf};
      pondt_pkg::IDX_NEXT_UPPER_B: rdv = sh ? 32'hff : {4'hf, m_hi[3:0]};
      pondt_pkg::IDX_ENABLE_HIGH: rdv = m_en[15:8];
      pondt_pkg::IDX_ENABLE_LOW: rdv = m_en[7:0];
      pondt_pkg::IDX_PORT_DATA: rdv = m_pins[15:0];
      pondt_pkg::IDX_TRIG_SEL: rdv = m_sel[7:0];
      pondt_pkg::IDX_NEXT_LOWER: rdv = m_lo[7:0];
      default: rdv = 32'h0;
    endcase
  endfunction
  function automatic void wrm(input logic [31:0] i, input logic [31:0] d);
    logic sh;
    sh = m_sel[7:6] == m_sel[5:4];
    case (i)
      pondt_pkg::IDX_NEXT_UPPER_A: if (sh) m_hi = d[7:0];
        else m_hi[7:4] = d[7:4];
      pondt_pkg::IDX_NEXT_UPPER_B: if (!sh) m_hi[3:0] = d[3:0];
      pondt_pkg::IDX_ENABLE_HIGH: m_en[15:8] = d[7:0];
      pondt_pkg::IDX_ENABLE_LOW: m_en[7:0] = d[7:0];
      pondt_pkg::IDX_PORT_DATA: m_pins = (d[15:0] & ~m_en[15:0]) | (m_pins & m_en);
      pondt_pkg::IDX_TRIG_SEL: m_sel = d[7:0];
      pondt_pkg::IDX_NEXT_LOWER: m_lo = d[7:0];
      default: ;
    endcase
  endfunction
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while ((awv && !ta) || (wv && !tw));
    @(negedge clk);
    while (!bv) @(negedge clk);
    r = br;
    @(posedge clk);
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    @(negedge clk);
    while (!arr) @(negedge clk);
    @(posedge clk);
    arv <= 1'b0;
    @(negedge clk);
    while (!rv) @(negedge clk);
    d = rd;
    r = rr;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] i, input logic [31:0] d);
    logic [1:0] r;
    axw(i * pondt_pkg::BYTES_PER_REG, d, r);
    chk({30'h0, r}, {30'h0, pondt_pkg::RESP_OKAY});
    wrm(i, d);
  endtask
  task automatic rdall;
    logic [31:0] d;
    logic [1:0] r;
    foreach (idx[k]) begin
      axr(idx[k] * pondt_pkg::BYTES_PER_REG, d, r);
      chk(d, rdv(idx[k]));
      chk({30'h0, r}, {30'h0, pondt_pkg::RESP_OKAY});
    end
    chk({16'h0, pen}, m_en[15:0]);
  endtask
  task automatic fire(input int c);
    int mk;
    go <= 1'b1;
    ch <= c[1:0];
    dly <= 4'($urandom_range(0, 6));
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
    end while (cmp == 4'h0);
    chk({28'h0, cmp}, 32'h1 << c);
    chk({16'h0, pins}, m_pins);
    for (int g = 0; g < 4; g++) begin
      if (((m_sel >> (2 * g)) & 3) == c) begin
        mk = m_en & (32'hf << (4 * g));
        m_pins = (m_pins & ~mk) | (((m_hi << 8) | m_lo) & mk);
      end
    end
    @(posedge clk);
    @(negedge clk);
    chk({16'h0, pins}, m_pins);
    @(posedge clk);
  endtask
  task automatic rst_seq;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    m_hi = 0;
    m_lo = 0;
    m_en = 0;
    m_pins = 0;
    m_sel = 8'hff;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    wrap_up;
  end
  initial begin
    logic [31:0] s, v;
    logic [1:0] r;
    logic sh;
    {awv, wv, arv, go, ch, dly, awa, wd, ara} = '0;
    bre = 1'b1;
    rre = 1'b1;
    errors = 0;
    check_count = 0;
    idx = '{pondt_pkg::IDX_NEXT_UPPER_A, pondt_pkg::IDX_NEXT_UPPER_B, pondt_pkg::IDX_ENABLE_HIGH,
      pondt_pkg::IDX_ENABLE_LOW, pondt_pkg::IDX_PORT_DATA, pondt_pkg::IDX_TRIG_SEL,
      pondt_pkg::IDX_NEXT_LOWER};
    void'($urandom(4));
    rst_seq();
    rdall();
    for (int t = 0; t < 10; t++) begin
      s = (t == 0) ? 32'hff : $urandom & 32'hff;
      wr(pondt_pkg::IDX_TRIG_SEL, s);
      sh = s[7:6] == s[5:4];
      v = $urandom;
      wr(pondt_pkg::IDX_NEXT_UPPER_A, sh ? v & 32'hff : {v[7:4], 4'hf});
      wr(pondt_pkg::IDX_NEXT_UPPER_B, sh ? 32'hff : {4'hf, v[11:8]});
      wr(pondt_pkg::IDX_ENABLE_HIGH, $urandom & 32'hff);
      wr(pondt_pkg::IDX_ENABLE_LOW, $urandom & 32'hff);
      wr(pondt_pkg::IDX_NEXT_LOWER, $urandom & 32'hff);
      wr(pondt_pkg::IDX_PORT_DATA, $urandom & 32'hffff);
      rdall();
      for (int c = 0; c < 4; c++) fire(c);
    end
    axw(32'h100, 32'hff, r);
    chk({30'h0, r}, {30'h0, pondt_pkg::RESP_SLVERR});
    axr(32'h100, v, r);
    chk(v, 32'h0);
    chk({30'h0, r}, {30'h0, pondt_pkg::RESP_SLVERR});
    rst_seq();
    rdall();
    wrap_up;
  end
endmodule // test_pattern_output_next_data_trigger
`default_nettype wire
